// ### rtl/post_div_defines.svh
// Overview of operation
// - Top nibble 1111 on a frame-capable divider gives a frame pulse, else a clock.
// - In clock mode on a frame-capable divider the whole value is the divide ratio, at most 0xefffff.
// - Frame polarity bit 18 clear gives a normal pulse, set gives it inverted.
// - A frame pulse routed to a configurable pin has its polarity reversed.
// - Type bit 19 clear centres the boundary in the pulse, set puts it on an edge.
// - Bits 15:0 count related clock periods between two frame pulses.
// - Bits 17:16 pick the related clock; the pulse is one of its periods wide.
// - Synthesizer 1 divider A divides by the unsigned value in bits 22:0.
// - Synthesizer 1 divider B divides by the unsigned value in bits 22:0.
// - Odd ratios give a high time below half; even ratios give exact halves.
// - Synthesizer 0 divider D codes 00, 01, 10 pick its A, B, C; 11 is unused.
`ifndef POST_DIV_DEFINES_SVH
`define POST_DIV_DEFINES_SVH

// Register indices; byte address is four times the index
`define PD_IDX_S0_D    8'h89
`define PD_IDX_S1_A    8'h8c
`define PD_IDX_S1_B    8'h8f
`define PD_IDX_S1_C    8'h92
`define PD_IDX_STATUS  8'h98

// Reset values
`define PD_RST_S0_D    24'h000040
`define PD_RST_S1_A    24'h000002
`define PD_RST_S1_B    24'h000002
`define PD_RST_S1_C    24'h000032

// Field positions
`define PD_MODE_HI     23
`define PD_MODE_LO     20
`define PD_TYPE_BIT    19
`define PD_POLAR_BIT   18
`define PD_SEL_HI      17
`define PD_SEL_LO      16
`define PD_PER_HI      15
`define PD_PLAIN_HI    22

// Codes and limits
`define PD_FRAME_CODE  4'hf
`define PD_MAX_RATIO   24'hefffff
`define PD_MIN_RATIO   24'h000002
`define PD_ALL_BYTES   3'h7

`endif

// ### rtl/post_div_pkg.sv
`default_nettype none
package post_div_pkg;

  // Bus slave answer state
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  typedef logic [23:0] ratio_t;

endpackage
`default_nettype wire

// ### rtl/synth_post_divider_frame_pulse.sv
`include "post_div_defines.svh"
`default_nettype none
module synth_post_divider_frame_pulse
  import post_div_pkg::*;
#(
  parameter int unsigned NUM_CH = 4
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Sibling divider clocks, same clock domain
  input  wire logic [2:0]  s0_div_clk,
  input  wire logic        s1_div_d_clk,
  // Frame pulse routed to a configurable pin
  input  wire logic [1:0]  frm_on_cfg_pin,
  // Divider outputs: s0 D, s1 A, s1 B, s1 C
  output logic [NUM_CH-1:0] div_clk_out
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  bus_state_t bus_q;
  bus_state_t bus_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire req = avs_read | avs_write;
  wire [7:0] idx = avs_address[9:2];
  wire wr_go = avs_write & (bus_q == BUS_ACK);
  wire rd_take = avs_read & (bus_q == BUS_IDLE);
  wire [NUM_CH-1:0] hit;
  wire hit_st = idx == `PD_IDX_STATUS;

  // One wait cycle, so read data can come from a flop
  assign bus_d = (req && bus_q == BUS_IDLE) ? BUS_ACK : BUS_IDLE;
  assign avs_waitrequest = req & (bus_q == BUS_IDLE);
  assign avs_readdata = rdata_q;

  // Address decode
  assign hit[0] = idx == `PD_IDX_S0_D;
  assign hit[1] = idx == `PD_IDX_S1_A;
  assign hit[2] = idx == `PD_IDX_S1_B;
  assign hit[3] = idx == `PD_IDX_S1_C;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_q   <= BUS_IDLE;
      rdata_q <= 32'h0;
    end else begin
      bus_q <= bus_d;
      if (rd_take) begin
        rdata_q <= rdata_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers with byte staging

  localparam ratio_t RST_VAL [NUM_CH] = '{`PD_RST_S0_D, `PD_RST_S1_A,
                                         `PD_RST_S1_B, `PD_RST_S1_C};

  ratio_t     sh_q   [NUM_CH];
  ratio_t     act_q  [NUM_CH];
  logic [2:0] mask_q [NUM_CH];
  logic [23:0] cnt_q [NUM_CH];
  ratio_t     eff    [NUM_CH];
  logic [NUM_CH-1:0] dclk_q;
  logic [NUM_CH-1:0] pend;
  logic [NUM_CH-1:0] fm4;
  logic [NUM_CH-1:0] frm_lvl4;
  logic [NUM_CH-1:0] out_q;
  wire [2:0] be = avs_byteenable[2:0];

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    wire wr_i = wr_go & hit[i];
    wire [2:0] mask_n = mask_q[i] | be;
    wire commit = wr_i & (mask_n == `PD_ALL_BYTES);
    wire [23:0] merged = {
      be[2] ? avs_writedata[23:16] : sh_q[i][23:16],
      be[1] ? avs_writedata[15:8]  : sh_q[i][15:8],
      be[0] ? avs_writedata[7:0]   : sh_q[i][7:0]};
    // Plain dividers ignore the reserved top bit
    wire plain = (i == 1) || (i == 2);
    wire [23:0] ratio = plain ?
      {1'b0, act_q[i][`PD_PLAIN_HI:0]} : act_q[i];
    wire [23:0] cnt_n;
    // Ratios below two cannot be made from a counter; clamp them
    assign eff[i] = (ratio < `PD_MIN_RATIO) ? `PD_MIN_RATIO : ratio;
    assign cnt_n = (cnt_q[i] >= eff[i] - 24'd1) ? 24'd0 :
                   cnt_q[i] + 24'd1;
    assign pend[i] = |mask_q[i];
    assign fm4[i] = ((i == 0) || (i == 3)) &&
      (act_q[i][`PD_MODE_HI:`PD_MODE_LO] == `PD_FRAME_CODE);

    // Partial writes wait in the shadow until the last byte lands
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        sh_q[i]   <= RST_VAL[i];
        act_q[i]  <= RST_VAL[i];
        mask_q[i] <= 3'h0;
      end else if (wr_i) begin
        sh_q[i]   <= merged;
        mask_q[i] <= commit ? 3'h0 : mask_n;
        if (commit) begin
          act_q[i] <= merged;
        end
      end
    end

    // High for the floor of half the ratio: odd ratios run short
    always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
        cnt_q[i]  <= 24'd0;
        dclk_q[i] <= 1'b0;
      end else begin
        cnt_q[i]  <= cnt_n;
        dclk_q[i] <= cnt_n < (eff[i] >> 1);
      end
    end
  end

  // Read mux
  always_comb begin
    rdata_d = 32'h0;
    for (int k = 0; k < NUM_CH; k++) begin
      if (hit[k]) begin
        rdata_d = {8'h00, act_q[k]};
      end
    end
    if (hit_st) begin
      rdata_d = {20'h0, out_q, fm4, pend};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame pulse generators: slot 0 is s0 D, slot 1 is s1 C

  wire [1:0] sel0 = act_q[0][`PD_SEL_HI:`PD_SEL_LO];
  wire [1:0] sel1 = act_q[3][`PD_SEL_HI:`PD_SEL_LO];
  wire [3:0] rel_src0 = {1'b0, s0_div_clk};
  wire [3:0] rel_src1 = {s1_div_d_clk, 1'b0, dclk_q[2], dclk_q[1]};
  // Reserved codes would point back at the divider itself
  wire [1:0] rel_ok = {sel1 != 2'b10, sel0 != 2'b11};
  wire [1:0] rel_lvl = {rel_src1[sel1], rel_src0[sel0]};
  wire [1:0] fm2 = {fm4[3], fm4[0]};
  ratio_t fcfg [2];
  logic [1:0]  prev_q;
  logic [1:0]  pulse_q;
  logic [15:0] fcnt_q [2];
  logic [1:0]  rise;
  logic [1:0]  at_last;
  logic [1:0]  frm_lvl;

  assign fcfg[0] = act_q[0];
  assign fcfg[1] = act_q[3];

  for (genvar f = 0; f < 2; f++) begin : g_frm
    wire [15:0] per = fcfg[f][`PD_PER_HI:0];
    wire [15:0] last = (per == 16'd0) ? 16'd0 : per - 16'd1;
    wire fall = ~rel_lvl[f] & prev_q[f];
    wire run = fm2[f] & rel_ok[f];
    wire gci = fcfg[f][`PD_TYPE_BIT];
    assign rise[f] = rel_lvl[f] & ~prev_q[f];
    assign at_last[f] = fcnt_q[f] >= last;
    // Pin routing flips the sense once more
    assign frm_lvl[f] = pulse_q[f] ^ fcfg[f][`PD_POLAR_BIT]
                        ^ frm_on_cfg_pin[f];

    // Count related periods; wrap marks the frame boundary
    always_ff @(posedge clk_sys) begin
      if (!rst_b || !run) begin
        fcnt_q[f] <= 16'd0;
      end else if (rise[f]) begin
        fcnt_q[f] <= at_last[f] ? 16'd0 : fcnt_q[f] + 16'd1;
      end
    end

    // Edge style starts on the boundary; centred style starts half early
    always_ff @(posedge clk_sys) begin
      if (!rst_b || !run) begin
        pulse_q[f] <= 1'b0;
        prev_q[f]  <= 1'b0;
      end else begin
        prev_q[f] <= rel_lvl[f];
        if (gci && rise[f]) begin
          pulse_q[f] <= at_last[f];
        end else if (!gci && fall) begin
          pulse_q[f] <= at_last[f];
        end
      end
    end
  end

  assign frm_lvl4 = {frm_lvl[1], 2'b00, frm_lvl[0]};

  ////////////////////////////////////////////////////////////////////////////
  // Output stage

  // Frame mode takes over the pin only on frame-capable channels
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      out_q <= '0;
    end else begin
      out_q <= (fm4 & frm_lvl4) | (~fm4 & dclk_q);
    end
  end

  assign div_clk_out = out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  clock_mode_a: assert property (
    !fm4[0] |=> out_q[0] == $past(dclk_q[0]))
    else $error("clock mode output does not follow divider");

  frame_mode_a: assert property (
    fm4[3] |=> out_q[3] == $past(frm_lvl4[3]))
    else $error("frame mode output does not follow pulse");

  ratio_cap_a: assert property (
    !fm4[0] && act_q[0] >= `PD_MIN_RATIO |-> eff[0] == act_q[0])
    else $error("clock mode ratio not whole register");

  idle_polar_a: assert property (
    (fm4[0] && !rel_ok[0] && !frm_on_cfg_pin[0])[*2]
    |=> out_q[0] == $past(act_q[0][`PD_POLAR_BIT]))
    else $error("idle frame level ignores polarity");

  pin_invert_a: assert property (
    (fm4[3] && !rel_ok[1] && frm_on_cfg_pin[1])[*2]
    |=> out_q[3] == !$past(act_q[3][`PD_POLAR_BIT]))
    else $error("pin routing did not invert pulse");

  gci_start_a: assert property (
    $rose(pulse_q[1]) && $past(act_q[3][`PD_TYPE_BIT])
    |-> $past(rise[1] && at_last[1]))
    else $error("edge style pulse began off boundary");

  frame_wrap_a: assert property (
    $rose(pulse_q[0]) && $past(act_q[0][`PD_TYPE_BIT])
    |-> fcnt_q[0] == 16'd0)
    else $error("frame pulse not at period wrap");

  reserved_sel_a: assert property (
    (fm4[3] && !rel_ok[1]) |=> !pulse_q[1])
    else $error("reserved selector produced a pulse");

  div_a_range_a: assert property (
    !$changed(eff[1]) |-> cnt_q[1] < eff[1])
    else $error("divider A counter beyond ratio");

  div_b_range_a: assert property (
    !$changed(eff[2]) |-> cnt_q[2] < eff[2])
    else $error("divider B counter beyond ratio");

  partial_hold_a: assert property (
    wr_go && hit[2] && ((mask_q[2] | be) != `PD_ALL_BYTES)
    |=> $stable(act_q[2]))
    else $error("ratio changed on partial write");

  bus_answer_a: assert property (
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not one cycle late");

  // Plain dividers take their ratio from the low field only
  plain_a_mask_a: assert property (
    act_q[1][`PD_PLAIN_HI:0] >= 23'd2
    |-> eff[1] == {1'b0, act_q[1][`PD_PLAIN_HI:0]})
    else $error("divider A ratio not from low field");

  plain_b_mask_a: assert property (
    act_q[2][`PD_PLAIN_HI:0] >= 23'd2
    |-> eff[2] == {1'b0, act_q[2][`PD_PLAIN_HI:0]})
    else $error("divider B ratio not from low field");

  // High time is the lower half of each count cycle
  duty_a_a: assert property (
    $stable(eff[1]) && $past(rst_b)
    |-> dclk_q[1] == (cnt_q[1] < (eff[1] >> 1)))
    else $error("divider A high time wrong");

  duty_b_a: assert property (
    $stable(eff[2]) && $past(rst_b)
    |-> dclk_q[2] == (cnt_q[2] < (eff[2] >> 1)))
    else $error("divider B high time wrong");

  // Frame pulse shape and spacing
  centre_pulse_a: assert property (
    $rose(pulse_q[0]) && !$past(act_q[0][`PD_TYPE_BIT])
    |-> $past(!rel_lvl[0] && prev_q[0] && at_last[0]))
    else $error("centred pulse began off falling edge");

  pulse_end_a: assert property (
    $fell(pulse_q[1]) && $past(fm4[3] && rel_ok[1] && act_q[3][`PD_TYPE_BIT])
    |-> $past(rise[1]))
    else $error("edge style pulse not one related period");

  count_step_a: assert property (
    rise[0] && !at_last[0] && fm2[0] && rel_ok[0]
    |=> fcnt_q[0] == $past(fcnt_q[0]) + 16'd1)
    else $error("frame period counter skipped");

  count_wrap_a: assert property (
    rise[1] && at_last[1] && fm2[1] && rel_ok[1] |=> fcnt_q[1] == 16'd0)
    else $error("frame period counter did not wrap");

  // Related clock selection per code
  rel_d_sel_a: assert property (
    sel1 == 2'b11 |-> rel_lvl[1] == s1_div_d_clk)
    else $error("code 11 did not pick divider D");

  rel_b_sel_a: assert property (
    sel1 == 2'b01 |-> rel_lvl[1] == dclk_q[2])
    else $error("code 01 did not pick divider B");

  s0_sel_b_a: assert property (
    sel0 == 2'b01 |-> rel_lvl[0] == s0_div_clk[1])
    else $error("code 01 did not pick synth0 B");

  s0_sel_c_a: assert property (
    sel0 == 2'b10 |-> rel_lvl[0] == s0_div_clk[2])
    else $error("code 10 did not pick synth0 C");

  frame_on_c: cover property (fm4[3] && rel_ok[1] ##[1:200] $rose(out_q[3]));
  commit_c: cover property (wr_go && hit[2] && mask_q[2] != 3'h0);
  gci_pulse_c: cover property ($rose(pulse_q[1]) && act_q[3][`PD_TYPE_BIT]);
  read_c: cover property (avs_read && !avs_waitrequest && hit_st);
  frame_centre_c: cover property ($rose(pulse_q[0]) && !act_q[0][`PD_TYPE_BIT]);

endmodule
`default_nettype wire

// ### sim/synth_post_divider_frame_pulse_tb_top.sv
`include "post_div_defines.svh"
`default_nettype none
module synth_post_divider_frame_pulse_tb_top
  import post_div_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // One compare: counts every check, reports and counts each mismatch
  `define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
    n_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

  typedef struct packed {
    logic [1:0]  ch;
    logic [23:0] v;
    logic        pin;
    logic [7:0]  win;
    logic [7:0]  ex;
  } div_case_t;

  // Windows are whole multiples of the expected output period, so the
  // high count does not depend on where the free-running counters stand
  // A and B keep bit 23 zero; selectors name a sibling, apart from the
  // two reserved-code misuse probes
  localparam div_case_t TAB [16] = '{
    '{2'd1, 24'h000004, 1'b0, 8'd84, 8'd42},
    '{2'd1, 24'h000006, 1'b0, 8'd84, 8'd42},
    '{2'd2, 24'h000007, 1'b0, 8'd84, 8'd36},
    '{2'd2, 24'h000003, 1'b0, 8'd84, 8'd28},
    '{2'd0, 24'h000006, 1'b0, 8'd84, 8'd42},
    '{2'd0, 24'hf80003, 1'b0, 8'd48, 8'd16},
    '{2'd0, 24'hfc0003, 1'b0, 8'd48, 8'd32},
    '{2'd0, 24'hf80003, 1'b1, 8'd48, 8'd32},
    '{2'd0, 24'hf00003, 1'b0, 8'd48, 8'd16},
    '{2'd0, 24'hf90003, 1'b0, 8'd48, 8'd16},
    '{2'd0, 24'hf80005, 1'b0, 8'd60, 8'd12},
    '{2'd0, 24'hf70003, 1'b0, 8'd48, 8'd48},
    '{2'd0, 24'hfa0002, 1'b0, 8'd48, 8'd24},
    '{2'd3, 24'hfb0002, 1'b0, 8'd48, 8'd24},
    '{2'd3, 24'hfe0002, 1'b1, 8'd48, 8'd0},
    '{2'd3, 24'hf90002, 1'b0, 8'd48, 8'd24}
  };
  localparam logic [9:0] ADDR [4] = '{10'h224, 10'h230, 10'h23c, 10'h248};

  logic        clk_sys        = 1'b0;
  logic        rst_b          = 1'b0;
  logic [9:0]  avs_address    = 10'h000;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [2:0]  s0_div_clk     = 3'h0;
  logic        s1_div_d_clk   = 1'b0;
  logic [1:0]  frm_on_cfg_pin = 2'h0;
  logic [3:0]  div_clk_out;
  logic [2:0]  rel_q          = 3'h0;
  int          n_errors       = 0;
  int          checked        = 0;
  int          cycles         = 0;

  ////////////////////////////////////////////////////////////////////////
  // 100 ns system clock
  always #50 clk_sys = ~clk_sys;

  // Sibling dividers: A period 4, B period 2, C and synth1 D period 8
  always @(posedge clk_sys) begin
    rel_q        <= rel_q + 3'h1;
    s0_div_clk   <= {rel_q[2], rel_q[0], rel_q[1]};
    s1_div_d_clk <= rel_q[2];
  end

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  synth_post_divider_frame_pulse i_dut (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .s0_div_clk      (s0_div_clk),
    .s1_div_d_clk    (s1_div_d_clk),
    .frm_on_cfg_pin  (frm_on_cfg_pin),
    .div_clk_out     (div_clk_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Avalon access; request held until the rising edge that samples
  // waitrequest low, where read data is taken and the request released
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge clk_sys);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Cycles with the output high across a window
  task automatic hi_count(input int ch, input int win, output int h);
    h = 0;
    repeat (win) begin
      @(negedge clk_sys);
      if (div_clk_out[ch] === 1'b1) h++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Reset values, then an unmapped place that must stay inert
  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, 10'h224, 32'h0, 4'h0, q);
    `CHK("s0_d_rst", {8'h00, `PD_RST_S0_D}, q)
    bus(1'b0, 10'h230, 32'h0, 4'h0, q);
    `CHK("s1_a_rst", {8'h00, `PD_RST_S1_A}, q)
    bus(1'b0, 10'h23c, 32'h0, 4'h0, q);
    `CHK("s1_b_rst", {8'h00, `PD_RST_S1_B}, q)
    bus(1'b0, 10'h248, 32'h0, 4'h0, q);
    `CHK("s1_c_rst", {8'h00, `PD_RST_S1_C}, q)
    bus(1'b1, 10'h3fc, 32'h00ffffff, 4'hf, q);
    bus(1'b0, 10'h3fc, 32'h0, 4'h0, q);
    `CHK("unmapped", 32'h0, q)
    bus(1'b0, 10'h230, 32'h0, 4'h0, q);
    `CHK("s1_a_kept", {8'h00, `PD_RST_S1_A}, q)
  endtask

  // A ratio split over two writes only goes live when complete
  task automatic t_partial();
    logic [31:0] q;
    bus(1'b1, 10'h23c, 32'h00000006, 4'h1, q);
    bus(1'b0, 10'h23c, 32'h0, 4'h0, q);
    `CHK("s1_b_half", 32'h00000002, q)
    bus(1'b0, 10'h260, 32'h0, 4'h0, q);
    `CHK("status_pend", 8'h04, q[7:0])
    bus(1'b1, 10'h23c, 32'h0, 4'h6, q);
    bus(1'b0, 10'h23c, 32'h0, 4'h0, q);
    `CHK("s1_b_full", 32'h00000006, q)
  endtask

  // Clock and frame shapes on every channel, judged by high time
  task automatic t_table();
    logic [31:0] q;
    int          h;
    foreach (TAB[i]) begin
      bus(1'b1, ADDR[TAB[i].ch], {8'h00, TAB[i].v}, 4'h7, q);
      frm_on_cfg_pin <= TAB[i].pin ? (TAB[i].ch == 3 ? 2'h2 : 2'h1) : 2'h0;
      bus(1'b0, ADDR[TAB[i].ch], 32'h0, 4'h0, q);
      `CHK("readback", {8'h00, TAB[i].v}, q)
      repeat (64) @(posedge clk_sys);
      hi_count(TAB[i].ch, TAB[i].win, h);
      `CHK("high_cycles", int'(TAB[i].ex), h)
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Reset held 20 cycles, released on a rising edge
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset();
    t_partial();
    t_table();
    end_sim();
  end

endmodule
`default_nettype wire
